/* File: src/icw_pkg.sv */
package icw_pkg;
  // ============================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned T_HS_LOW_MS = 10;
  localparam int unsigned T_HS_DETECT_MS = 5;
  localparam int unsigned T_STARTUP_MS = 15;
  localparam int unsigned T_SETUP_MS = 22;
  localparam int unsigned T_CONV_MS = 4;
  localparam int unsigned T_RDY_WAIT_MS = 30;
  localparam int unsigned BUS_HZ = 400_000;
  localparam int unsigned QTR_CYC = CLK_HZ / (4 * BUS_HZ);
  localparam int TW = 24;
  localparam int QW = 8;
  localparam int unsigned POLL_MAX = 8;

  // ============================================================
  // Bus address and byte layout
  localparam logic [6:0] DEV_ADDR = 7'h44;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ============================================================
  // Memory map
  localparam int MEM_DEPTH = 32;
  localparam logic [7:0] LTA_FIRST = 8'h00;
  localparam logic [7:0] LTA_LAST = 8'h07;
  localparam logic [7:0] SET_FIRST = 8'h10;
  localparam logic [7:0] SET_LAST = 8'h17;
  localparam logic [7:0] DEFADDR_REG = 8'h10;
  localparam logic [7:0] MODE_REG = 8'h11;
  localparam int EVENT_BIT = 0;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] ZERO_RST = 8'h00;

  function automatic int unsigned ms_cycles(input int unsigned ms);
    return ms * CYC_PER_MS;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return ((a >= LTA_FIRST) && (a <= LTA_LAST)) || ((a >= SET_FIRST) && (a <= SET_LAST));
  endfunction
endpackage

/* File: src/icw_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface icw_if;
  // ============================================================
  // Open-drain drivers of each end
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_rdy_o;
  logic dev_rdy_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic host_rdy_o;
  logic host_rdy_oe;
  // Wire levels with pull-ups
  logic scl;
  logic sda;
  logic rdy;

  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (dev_sda_oe ? dev_sda_o : 1'b1) & (host_sda_oe ? host_sda_o : 1'b1);
  assign rdy = (dev_rdy_oe ? dev_rdy_o : 1'b1) & (host_rdy_oe ? host_rdy_o : 1'b1);

  modport device (input scl, input sda, input rdy, output dev_sda_o, output dev_sda_oe, output dev_rdy_o,
    output dev_rdy_oe);
  modport host (input scl, input sda, input rdy, output host_scl_o, output host_scl_oe, output host_sda_o,
    output host_sda_oe, output host_rdy_o, output host_rdy_oe);
endinterface
`default_nettype wire

/* File: src/icw_host.sv */
`timescale 1ns/1ns
`default_nettype none
module icw_host #(
  parameter int unsigned HS_CYC = icw_pkg::ms_cycles(icw_pkg::T_HS_LOW_MS),
  parameter int unsigned RDY_WAIT_CYC = icw_pkg::ms_cycles(icw_pkg::T_RDY_WAIT_MS)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bus pins
  icw_if.host bus,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_handshake,
  input wire logic cmd_poll,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_data,
  output logic done,
  output logic nack
);
  typedef enum logic [6:0] {
    H_IDLE = 7'b0000001,
    H_HSLOW = 7'b0000010,
    H_HSWAIT = 7'b0000100,
    H_START = 7'b0001000,
    H_BIT = 7'b0010000,
    H_STOP = 7'b0100000,
    H_DONE = 7'b1000000
  } icw_host_state_e;

  icw_host_state_e st_q;
  logic [icw_pkg::TW-1:0] tmr_q;
  logic [icw_pkg::QW-1:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [1:0] idx_q;
  logic [3:0] try_q;
  logic ack_q;
  logic hs_q;
  logic poll_q;
  logic [7:0] reg_q;
  logic [7:0] dat_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic done_q;
  logic nack_q;

  // ============================================================
  // Quarter-bit enable and byte selection
  wire tick = (div_q == icw_pkg::QW'(icw_pkg::QTR_CYC - 1));
  wire [7:0] tx = (idx_q == 2'h0) ? {icw_pkg::DEV_ADDR, icw_pkg::DIR_WRITE} : (idx_q == 2'h1) ? reg_q : dat_q;
  wire [2:0] bsel = 3'(4'h7 - bit_q);
  wire last_bit = (bit_q == icw_pkg::BITS_PER_BYTE);
  wire tries_left = (try_q < 4'(icw_pkg::POLL_MAX));

  assign cmd_ready = (st_q == H_IDLE);
  assign done = done_q;
  assign nack = nack_q;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_rdy_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_oe = sda_oe_q;
  assign bus.host_rdy_oe = (st_q == H_HSLOW); // RULE1

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
    end
  end

  // ============================================================
  // Transfer sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= H_IDLE;
      tmr_q <= '0;
      ph_q <= '0;
      bit_q <= '0;
      idx_q <= '0;
      try_q <= '0;
      ack_q <= 1'b0;
      hs_q <= 1'b0;
      poll_q <= 1'b0;
      reg_q <= '0;
      dat_q <= '0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (cmd_valid) begin
            hs_q <= cmd_handshake;
            poll_q <= cmd_poll;
            reg_q <= cmd_reg;
            dat_q <= cmd_data;
            try_q <= '0;
            tmr_q <= '0;
            ph_q <= '0;
            st_q <= cmd_handshake ? H_HSLOW : (cmd_poll ? H_START : H_HSWAIT); // RULE4
          end
        end
        H_HSLOW: begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == icw_pkg::TW'(HS_CYC - 1)) begin // RULE1
            tmr_q <= '0;
            st_q <= H_HSWAIT;
          end
        end
        H_HSWAIT: begin
          tmr_q <= tmr_q + 1'b1;
          if (!bus.rdy) begin
            ph_q <= '0;
            st_q <= H_START;
          end else if (tmr_q == icw_pkg::TW'(RDY_WAIT_CYC - 1)) begin
            try_q <= try_q + 1'b1;
            tmr_q <= '0;
            st_q <= (hs_q && tries_left) ? H_HSLOW : H_DONE; // RULE3 RULE7
            ack_q <= 1'b0;
          end
        end
        H_START: begin
          if (tick) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == 2'h0) begin
              sda_oe_q <= 1'b0;
              scl_oe_q <= 1'b0;
            end else if (ph_q == 2'h1) begin
              sda_oe_q <= 1'b1;
            end else if (ph_q == 2'h2) begin
              scl_oe_q <= 1'b1;
            end else begin
              bit_q <= '0;
              idx_q <= '0;
              st_q <= H_BIT; // RULE6
            end
          end
        end
        H_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == 2'h0) begin
              sda_oe_q <= last_bit ? 1'b0 : ~tx[bsel];
            end else if (ph_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else if (ph_q == 2'h2) begin
              if (last_bit) begin
                ack_q <= ~bus.sda;
              end
            end else begin
              scl_oe_q <= 1'b1;
              bit_q <= bit_q + 1'b1;
              if (last_bit) begin
                bit_q <= '0;
                idx_q <= idx_q + 1'b1;
                if (!ack_q || (idx_q == 2'h2)) begin
                  st_q <= H_STOP;
                end
              end
            end
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == 2'h0) begin
              sda_oe_q <= 1'b1;
            end else if (ph_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else if (ph_q == 2'h2) begin
              sda_oe_q <= 1'b0;
            end else if (!ack_q && (idx_q == 2'h1) && tries_left && (poll_q || hs_q)) begin
              try_q <= try_q + 1'b1;
              tmr_q <= '0;
              st_q <= hs_q ? H_HSLOW : H_START; // RULE3 RULE6 RULE7
            end else begin
              st_q <= H_DONE;
            end
          end
        end
        H_DONE: begin
          done_q <= 1'b1;
          nack_q <= ~ack_q;
          st_q <= H_IDLE;
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: src/icw_device.sv */
// Notes on behaviour
// RULE1: Host requests window by 10ms low pulse.
// RULE2: Device answers handshake by pulling ready low.
// RULE3: Host repeats handshake until address acknowledged.
// RULE4: Without polling, host waits or handshakes.
// RULE5: No address acknowledge during conversion.
// RULE6: Polling: start, control byte, retry on nack.
// RULE7: Host caps polling attempts.
// RULE8: Only handshake forces window in event mode.
// RULE9: Ready line driven regardless of host.
// RULE10: Setup window opens 15ms after power-up.
// RULE11: Unserviced setup window closes after 22ms.
// RULE12: Host writes settings before stop.
// RULE13: Repeated start keeps window open.
// RULE14: Stop closes window, conversion resumes.
// RULE15: Write: pointer byte then data bytes.
// RULE16: Pointer increments after each data byte.
// RULE17: Unmapped pointer discards written byte.
// RULE18: Pointer does not skip map gaps.
// RULE19: Respond only to address 0x44.
// RULE20: No acknowledge outside window.
// RULE21: Window opening loads pointer from default.
// RULE22: Ready released when window closed.
`timescale 1ns/1ns
`default_nettype none
module icw_device #(
  parameter int unsigned STARTUP_CYC = icw_pkg::ms_cycles(icw_pkg::T_STARTUP_MS),
  parameter int unsigned SETUP_CYC = icw_pkg::ms_cycles(icw_pkg::T_SETUP_MS),
  parameter int unsigned CONV_CYC = icw_pkg::ms_cycles(icw_pkg::T_CONV_MS),
  parameter int unsigned HS_DET_CYC = icw_pkg::ms_cycles(icw_pkg::T_HS_DETECT_MS)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bus pins
  icw_if.device bus,
  // Status
  output logic window_open,
  output logic event_mode,
  output logic converting,
  // Register write strobe
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  typedef enum logic [4:0] {
    D_POWERUP = 5'b00001,
    D_SETUP = 5'b00010,
    D_CONV = 5'b00100,
    D_WAITHS = 5'b01000,
    D_WIN = 5'b10000
  } icw_dev_state_e;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ADDR = 7'b0000010,
    S_AACK = 7'b0000100,
    S_WR = 7'b0001000,
    S_WACK = 7'b0010000,
    S_RD = 7'b0100000,
    S_RACK = 7'b1000000
  } icw_ser_state_e;

  icw_dev_state_e st_q;
  icw_ser_state_e ss_q;
  logic [icw_pkg::TW-1:0] tmr_q;
  logic [icw_pkg::TW-1:0] hs_cnt_q;
  logic hs_pend_q;
  logic scl_q;
  logic sda_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic ptr_first_q;
  logic rw_q;
  logic addressed_q;
  logic mack_q;
  logic [7:0] ptr_q;
  logic [7:0] mem_q [icw_pkg::MEM_DEPTH];
  logic wr_stb_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;

  // ============================================================
  // Bus conditions
  wire scl_rise = ~scl_q & bus.scl;
  wire scl_fall = scl_q & ~bus.scl;
  wire start_c = scl_q & bus.scl & sda_q & ~bus.sda;
  wire stop_c = scl_q & bus.scl & ~sda_q & bus.sda;
  wire byte_end = scl_fall && (cnt_q == icw_pkg::BITS_PER_BYTE);
  wire in_window = (st_q == D_SETUP) || (st_q == D_WIN);
  wire addr_hit = (sh_q[7:1] == icw_pkg::DEV_ADDR); // RULE19
  wire [4:0] ptr_idx = ptr_q[4:0];
  wire ptr_ok = icw_pkg::is_mapped(ptr_q);
  wire [7:0] rd_byte = ptr_ok ? mem_q[ptr_idx] : 8'h00;
  wire [7:0] def_ptr = mem_q[icw_pkg::DEFADDR_REG[4:0]];
  wire evt = mem_q[icw_pkg::MODE_REG[4:0]][icw_pkg::EVENT_BIT];
  wire mem_we = byte_end && (ss_q == S_WR) && !ptr_first_q && ptr_ok; // RULE17
  wire rdy_low_ext = ~bus.rdy & ~in_window;
  wire win_open_ev = ((st_q == D_POWERUP) && (tmr_q == icw_pkg::TW'(STARTUP_CYC - 1)))
    || ((st_q == D_CONV) && (tmr_q == icw_pkg::TW'(CONV_CYC - 1)) && (!evt || hs_pend_q))
    || ((st_q == D_WAITHS) && hs_pend_q);

  // ============================================================
  // Pin drive and status
  assign bus.dev_rdy_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_rdy_oe = in_window; // RULE2 RULE9 RULE22
  assign bus.dev_sda_oe = (ss_q == S_AACK) || (ss_q == S_WACK) || ((ss_q == S_RD) && !sh_q[7]);
  assign window_open = in_window;
  assign event_mode = evt;
  assign converting = (st_q == D_CONV);
  assign wr_stb = wr_stb_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  // ============================================================
  // Handshake detector
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hs_cnt_q <= '0;
      hs_pend_q <= 1'b0;
    end else begin
      hs_cnt_q <= rdy_low_ext ? hs_cnt_q + 1'b1 : '0;
      if (rdy_low_ext && (hs_cnt_q == icw_pkg::TW'(HS_DET_CYC - 1))) begin
        hs_pend_q <= 1'b1; // RULE2
      end else if (win_open_ev) begin
        hs_pend_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // Window sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= D_POWERUP;
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
      case (st_q)
        D_POWERUP: begin
          if (win_open_ev) begin
            tmr_q <= '0;
            st_q <= D_SETUP; // RULE10
          end
        end
        D_SETUP: begin
          if (stop_c) begin
            tmr_q <= '0;
            st_q <= D_CONV; // RULE14
          end else if (!addressed_q && (tmr_q >= icw_pkg::TW'(SETUP_CYC - 1))) begin
            tmr_q <= '0;
            st_q <= D_CONV; // RULE11
          end
        end
        D_CONV: begin
          if (tmr_q == icw_pkg::TW'(CONV_CYC - 1)) begin
            tmr_q <= '0;
            st_q <= win_open_ev ? D_WIN : D_WAITHS; // RULE8
          end
        end
        D_WAITHS: begin
          tmr_q <= '0;
          if (win_open_ev) begin
            st_q <= D_WIN; // RULE8
          end
        end
        D_WIN: begin
          tmr_q <= '0;
          if (stop_c) begin
            st_q <= D_CONV; // RULE14
          end
        end
        default: begin
          st_q <= D_POWERUP;
        end
      endcase
    end
  end

  // ============================================================
  // Register store
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < icw_pkg::MEM_DEPTH; i++) begin
        mem_q[i] <= icw_pkg::ZERO_RST;
      end
      mem_q[icw_pkg::MODE_REG[4:0]] <= icw_pkg::MODE_RST;
    end else if (mem_we) begin
      mem_q[ptr_idx] <= sh_q; // RULE15
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_stb_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      wr_stb_q <= mem_we;
      if (mem_we) begin
        wr_addr_q <= ptr_q;
        wr_data_q <= sh_q;
      end
    end
  end

  // ============================================================
  // Serial slave
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ss_q <= S_IDLE;
      sh_q <= '0;
      cnt_q <= '0;
      ptr_first_q <= 1'b0;
      rw_q <= 1'b0;
      addressed_q <= 1'b0;
      mack_q <= 1'b0;
      ptr_q <= '0;
    end else begin
      if (win_open_ev) begin
        ptr_q <= def_ptr; // RULE21
      end
      if (stop_c) begin
        ss_q <= S_IDLE;
        addressed_q <= 1'b0;
      end else if (start_c) begin
        ss_q <= S_ADDR; // RULE13
        cnt_q <= '0;
      end else begin
        if (scl_rise && ((ss_q == S_ADDR) || (ss_q == S_WR))) begin
          sh_q <= {sh_q[6:0], bus.sda};
          cnt_q <= cnt_q + 1'b1;
        end
        case (ss_q)
          S_ADDR: begin
            if (byte_end) begin
              rw_q <= sh_q[0];
              ptr_first_q <= (sh_q[0] == icw_pkg::DIR_WRITE);
              addressed_q <= addr_hit && in_window;
              ss_q <= (addr_hit && in_window) ? S_AACK : S_IDLE; // RULE5 RULE20
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              cnt_q <= '0;
              sh_q <= rd_byte;
              ss_q <= rw_q ? S_RD : S_WR;
            end
          end
          S_WR: begin
            if (byte_end) begin
              ss_q <= S_WACK;
              ptr_first_q <= 1'b0;
              ptr_q <= ptr_first_q ? sh_q : ptr_q + 1'b1; // RULE15 RULE16 RULE18
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              cnt_q <= '0;
              ss_q <= S_WR;
            end
          end
          S_RD: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 1'b1;
            end
            if (scl_fall) begin
              sh_q <= {sh_q[6:0], 1'b1};
              if (cnt_q == icw_pkg::BITS_PER_BYTE) begin
                ptr_q <= ptr_q + 1'b1;
                ss_q <= S_RACK;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              mack_q <= ~bus.sda;
            end
            if (scl_fall) begin
              cnt_q <= '0;
              sh_q <= rd_byte;
              ss_q <= mack_q ? S_RD : S_IDLE;
            end
          end
          default: begin
            ss_q <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/icw_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module icw_assertions #(
  parameter int unsigned STARTUP_CYC = 200,
  parameter int unsigned SETUP_CYC = 400,
  parameter int unsigned HS_DET_CYC = 50
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Wire and driver levels
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic dev_rdy_o,
  input wire logic dev_rdy_oe,
  input wire logic host_rdy_oe,
  // Device status
  input wire logic window_open,
  input wire logic converting,
  input wire logic wr_stb,
  input wire logic [7:0] wr_addr
);
  // ============================================================
  // Cycle counters and history flags
  logic [31:0] cyc_q;
  logic [31:0] open_q;
  logic [31:0] hs_q;
  logic seen_q;
  logic shut_q;
  logic acked_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cyc_q <= 32'h0;
      open_q <= 32'h0;
      hs_q <= 32'h0;
      seen_q <= 1'b0;
      shut_q <= 1'b0;
      acked_q <= 1'b0;
    end else begin
      cyc_q <= cyc_q + 32'h1;
      open_q <= window_open ? open_q + 32'h1 : 32'h0;
      hs_q <= (host_rdy_oe && !converting && !window_open) ? hs_q + 32'h1 : 32'h0;
      seen_q <= seen_q | window_open;
      shut_q <= shut_q | (seen_q & !window_open);
      acked_q <= acked_q | dev_sda_oe;
    end
  end

  // ============================================================
  // Bus conditions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence start_seq;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_seq;
    scl && $past(scl) && $rose(sda);
  endsequence

  // ============================================================
  // Properties
  AST_RDY_WINDOW: assert property (window_open |-> dev_rdy_oe && !dev_rdy_o)
    else $error("ready not pulled low in window");
  AST_RDY_RELEASED: assert property (!window_open |-> !dev_rdy_oe)
    else $error("ready held outside window");
  AST_NO_ACK_OUTSIDE: assert property (!window_open |-> !dev_sda_oe)
    else $error("data line pulled outside window");
  AST_NO_ACK_CONV: assert property (converting |-> !dev_sda_oe)
    else $error("acknowledge during conversion");
  AST_STOP_CLOSES: assert property (stop_seq ##0 window_open |-> ##[1:4] !window_open)
    else $error("window open after stop");
  AST_RESTART_KEEPS: assert property (start_seq ##0 window_open |=> window_open [*8])
    else $error("window lost on start");
  AST_CONV_RESUMES: assert property ($fell(window_open) |-> ##[0:3] converting)
    else $error("no conversion after window");
  AST_STARTUP_EARLY: assert property ($rose(window_open) && !seen_q |->
    (cyc_q + 32'h2 >= STARTUP_CYC) && (cyc_q <= STARTUP_CYC + 2))
    else $error("setup window opened off time");
  AST_STARTUP_LATE: assert property (cyc_q == STARTUP_CYC + 3 |-> seen_q || window_open)
    else $error("setup window missing");
  AST_SETUP_TIMEOUT: assert property (window_open && !shut_q && !acked_q |-> open_q <= SETUP_CYC + 2)
    else $error("unserviced setup window too long");
  AST_HS_OPENS: assert property ($fell(host_rdy_oe) && hs_q > HS_DET_CYC + 2 |-> ##[1:4] window_open)
    else $error("handshake not answered");
  AST_WR_MAPPED: assert property (wr_stb |-> window_open && (wr_addr <= icw_pkg::LTA_LAST ||
    (wr_addr >= icw_pkg::SET_FIRST && wr_addr <= icw_pkg::SET_LAST)))
    else $error("store outside map or window");
endmodule
`default_nettype wire

/* File: verification/i2c_slave_comm_window_test.sv */
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_comm_window_test;
  localparam int unsigned ST = 200;
  localparam int unsigned SU = 4000;
  localparam int unsigned CV = 100;
  localparam int unsigned HD = 50;
  localparam int unsigned HSL = 100;
  localparam int unsigned QT = 25;
  localparam int LIMIT = 98000;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_handshake = 1'b0;
  logic cmd_poll = 1'b0;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, done, nack, win1, ev1, cv1, stb1, win2, ev2, cv2, stb2;
  logic [7:0] wa1, wd1, wa2, wd2;
  logic [15:0] q1[$];
  logic [15:0] q2[$];
  int failures = 0;
  int compares = 0;
  int cyc = 0;

  icw_if bus1();
  icw_if bus2();

  icw_host #(.HS_CYC(HSL), .RDY_WAIT_CYC(600)) u_icw_host (.ref_clk(ref_clk), .resetn(resetn), .bus(bus1),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_handshake(cmd_handshake), .cmd_poll(cmd_poll),
    .cmd_reg(cmd_reg), .cmd_data(cmd_data), .done(done), .nack(nack));
  icw_device #(.STARTUP_CYC(ST), .SETUP_CYC(SU), .CONV_CYC(CV), .HS_DET_CYC(HD)) u_icw_device (
    .ref_clk(ref_clk), .resetn(resetn), .bus(bus1), .window_open(win1), .event_mode(ev1), .converting(cv1),
    .wr_stb(stb1), .wr_addr(wa1), .wr_data(wd1));
  icw_device #(.STARTUP_CYC(ST), .SETUP_CYC(SU), .CONV_CYC(CV), .HS_DET_CYC(HD)) u_icw_device_2 (
    .ref_clk(ref_clk), .resetn(resetn), .bus(bus2), .window_open(win2), .event_mode(ev2), .converting(cv2),
    .wr_stb(stb2), .wr_addr(wa2), .wr_data(wd2));
  icw_assertions #(.STARTUP_CYC(ST), .SETUP_CYC(SU), .HS_DET_CYC(HD)) u_icw_assertions (.ref_clk(ref_clk),
    .resetn(resetn), .scl(bus1.scl), .sda(bus1.sda), .dev_sda_oe(bus1.dev_sda_oe), .dev_rdy_o(bus1.dev_rdy_o),
    .dev_rdy_oe(bus1.dev_rdy_oe), .host_rdy_oe(bus1.host_rdy_oe), .window_open(win1), .converting(cv1),
    .wr_stb(stb1), .wr_addr(wa1));

  always #5 ref_clk = ~ref_clk;

  // ============================================================
  // Store capture and hang guard
  // Strobes sampled mid-cycle, away from the edge that launches them
  always @(negedge ref_clk) begin
    if (stb1 === 1'b1) q1.push_back({wa1, wd1});
    if (stb2 === 1'b1) q2.push_back({wa2, wd2});
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report;
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_cyc(input int n);
    while (cyc < n) tick(1);
  endtask

  // ============================================================
  // Host command through the host end
  task automatic host_cmd(input logic hs, input logic pl, input logic [7:0] r, input logic [7:0] d,
    input logic xn, input int xc, input logic [15:0] xs);
    int n;
    q1.delete();
    cmd_handshake = hs;
    cmd_poll = pl;
    cmd_reg = r;
    cmd_data = d;
    cmd_valid = 1'b1;
    // Ready checked settled, then the next edge takes the command
    while (cmd_ready !== 1'b1) tick(1);
    tick(1);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 50000) begin
      tick(1);
      n++;
    end
    chk("done", 1'b1, done);
    chk("nack", xn, nack);
    chk("store count", xc, q1.size());
    if (xc > 0) chk("store", xs, q1[0]);
  endtask

  // ============================================================
  // Bit-level driver on the second link
  task automatic drv(input logic scl_lo, input logic sda_lo);
    bus2.host_scl_oe = scl_lo;
    bus2.host_sda_oe = sda_lo;
    tick(QT);
  endtask

  task automatic bb_start;
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
  endtask

  task automatic bb_stop;
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
    drv(1'b0, 1'b0);
  endtask

  task automatic bb_byte(input logic [7:0] v, input logic xa);
    logic ack;
    for (int i = 7; i >= 0; i--) begin
      drv(1'b1, !v[i]);
      drv(1'b0, !v[i]);
      drv(1'b0, !v[i]);
      drv(1'b1, !v[i]);
    end
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
    ack = !bus2.sda;
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    chk("ack", xa, ack);
  endtask

  initial begin
    bus2.host_scl_o = 1'b0;
    bus2.host_sda_o = 1'b0;
    bus2.host_rdy_o = 1'b0;
    bus2.host_scl_oe = 1'b0;
    bus2.host_sda_oe = 1'b0;
    bus2.host_rdy_oe = 1'b0;
    tick(6);
    resetn = 1'b1;
    fork
      begin
        host_cmd(1'b0, 1'b1, 8'h12, 8'hA5, 1'b0, 1, 16'h12A5);
        host_cmd(1'b1, 1'b0, 8'h11, 8'h00, 1'b0, 1, 16'h1100);
        chk("event mode", 1'b0, ev1);
        host_cmd(1'b0, 1'b0, 8'h17, 8'h3C, 1'b0, 1, 16'h173C);
        host_cmd(1'b0, 1'b1, 8'h08, 8'h77, 1'b0, 0, 16'h0000);
        host_cmd(1'b0, 1'b1, 8'h11, 8'h01, 1'b0, 1, 16'h1101);
        host_cmd(1'b0, 1'b1, 8'h13, 8'h99, 1'b1, 0, 16'h0000);
      end
      begin
        wait_cyc(ST);
        chk("setup window early", 1'b0, win2);
        wait_cyc(ST + 15);
        chk("setup window", 1'b1, bus2.rdy === 1'b0);
        wait_cyc(ST + SU);
        chk("setup window held", 1'b1, win2);
        wait_cyc(ST + SU + 20);
        chk("ready released", 1'b1, bus2.rdy);
        chk("event mode kept", 1'b1, ev2);
        chk("converting", 1'b1, cv2);
        wait_cyc(ST + SU + CV + 200);
        chk("unasked window", 1'b0, win2);
        bb_start();
        bb_byte(8'h88, 1'b0);
        bb_stop();
        bus2.host_rdy_oe = 1'b1;
        tick(HSL);
        bus2.host_rdy_oe = 1'b0;
        tick(20);
        chk("handshake answer", 1'b0, bus2.rdy);
        bb_start();
        bb_byte(8'h8A, 1'b0);
        bb_start();
        bb_byte(8'h88, 1'b1);
        bb_byte(8'h07, 1'b1);
        bb_byte(8'h5A, 1'b1);
        bb_byte(8'h6B, 1'b1);
        bb_start();
        chk("window after restart", 1'b1, win2);
        bb_byte(8'h88, 1'b1);
        bb_byte(8'h0F, 1'b1);
        bb_byte(8'h11, 1'b1);
        bb_byte(8'h22, 1'b1);
        bb_stop();
        tick(10);
        chk("window after stop", 1'b0, win2);
        chk("store count", 2, q2.size());
        chk("first store", 16'h075A, q2[0]);
        chk("gap store", 16'h1022, q2[1]);
      end
    join
    final_report();
  end
endmodule
`default_nettype wire
